/* File: src/pes_event_shutdown.v */
`timescale 1ns/1ps
`include "pes_defs.vh"
module pes_event_shutdown #(
	parameter SECOND_INSTANCE = 0
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        trip_pin,
	input  wire        cmp1_in,
	input  wire        cmp2_in,
	input  wire        cmp3_in,
	input  wire [15:0] phase_count,
	input  wire [15:0] duty_count,
	input  wire [15:0] period_count,
	output reg  [5:0]  pwm_out,
	output reg         rise_evt,
	output reg         fall_evt,
	output reg         period_evt,
	output reg         shutdown_active,
	output reg         irq
);

	// Any enabled source in the selection hits.
	function pes_hit;
		input [7:0] sel;
		input [7:0] src;
		begin
			pes_hit = |(sel & src);
		end
	endfunction

	localparam [7:0] LVL_MASK = (SECOND_INSTANCE != 0) ? `PES_MASK_LVL_TWO
		: `PES_MASK_LVL_FULL;

	reg  [3:0] sync1_ff;
	reg  [3:0] sync2_ff;
	reg  [3:0] src_q_ff;
	reg  [7:0] rise_sel_ff;
	reg  [7:0] fall_sel_ff;
	reg  [7:0] per_sel_ff;
	reg  [7:0] sd_ctrl_ff;
	reg  [7:0] sd_lvl_ff;
	reg  [7:0] sd_src_ff;
	reg  [15:0] tb_cnt_ff;
	reg  [3:0] irq_stat_ff;
	reg  [3:0] irq_en_ff;
	reg        trip_q_ff;
	reg        pwm_lvl_ff;

	reg  [7:0]  nxt_sd_ctrl;
	reg  [15:0] nxt_tb_cnt;
	reg  [3:0]  nxt_irq_stat;
	reg         nxt_pwm_lvl;
	reg  [31:0] nxt_prdata;
	reg         nxt_unmapped;

	wire       setup_ph = psel & ~penable;
	wire       wr_acc   = psel & penable & pready & pwrite;
	wire [7:0] wbyte    = pwdata[7:0];

	// Source vector in selection layout: pin at bit 7, comparators at 3..1.
	wire [3:0] src_edge = sync2_ff & ~src_q_ff;
	wire [7:0] edge_vec = {src_edge[0], 3'b000, src_edge[3:1], 1'b0};
	wire [7:0] lvl_vec  = {sync2_ff[0], 3'b000, sync2_ff[3:1], 1'b0};

	wire ph_match  = (tb_cnt_ff == phase_count);
	wire dc_match  = (tb_cnt_ff == duty_count);
	wire pr_match  = (tb_cnt_ff == period_count);

	wire rise_hit = pes_hit(rise_sel_ff, {edge_vec[7:1], ph_match});
	wire fall_hit = pes_hit(fall_sel_ff, {edge_vec[7:1], dc_match});
	wire per_hit  = pes_hit(per_sel_ff, {edge_vec[7:1], pr_match});

	wire trip_lvl  = pes_hit(sd_src_ff, lvl_vec);
	wire trip_rise = trip_lvl & ~trip_q_ff;
	wire sd_en     = sd_ctrl_ff[`PES_BIT_SD_EN];
	wire sd_evt    = sd_en & trip_rise;

	wire forced = sd_ctrl_ff[`PES_BIT_STATUS] |
		(sd_en & sd_ctrl_ff[`PES_BIT_OVERRIDE]);

	// Shutdown control register write decode and shutdown status.
	always @*
	begin
		nxt_sd_ctrl = sd_ctrl_ff;
		if (wr_acc && paddr == `PES_OFS_SD_CTRL)
		begin
			nxt_sd_ctrl = wbyte & `PES_MASK_SD_CTRL;
		end
		if (sd_ctrl_ff[`PES_BIT_STATUS] && sd_ctrl_ff[`PES_BIT_RESTART] &&
			!trip_lvl)
		begin
			nxt_sd_ctrl[`PES_BIT_STATUS] = 1'b0;
		end
		if (sd_evt)
		begin
			nxt_sd_ctrl[`PES_BIT_STATUS] = 1'b1;
		end
	end

	// Time base counter.
	always @*
	begin
		nxt_tb_cnt = tb_cnt_ff + 16'h0001;
		if (per_hit)
		begin
			nxt_tb_cnt = `PES_RST_COUNT;
		end
		if (wr_acc && paddr == `PES_OFS_TB_LOW)
		begin
			nxt_tb_cnt = {tb_cnt_ff[15:8], wbyte};
		end
	end

	// Sticky event bits; a new event beats a simultaneous clear.
	always @*
	begin
		nxt_irq_stat = irq_stat_ff;
		if (wr_acc && paddr == `PES_OFS_IRQ_CLR)
		begin
			nxt_irq_stat = irq_stat_ff & ~wbyte[3:0];
		end
		if (rise_hit)
		begin
			nxt_irq_stat[`PES_IRQ_RISE] = 1'b1;
		end
		if (fall_hit)
		begin
			nxt_irq_stat[`PES_IRQ_FALL] = 1'b1;
		end
		if (per_hit)
		begin
			nxt_irq_stat[`PES_IRQ_PERIOD] = 1'b1;
		end
		// flag only from a real trip, never from override
		if (sd_evt)
		begin
			nxt_irq_stat[`PES_IRQ_SHUTDOWN] = 1'b1;
		end
	end

	// Simple waveform: high from rising to falling event.
	always @*
	begin
		nxt_pwm_lvl = pwm_lvl_ff;
		if (rise_hit)
		begin
			nxt_pwm_lvl = 1'b1;
		end
		if (fall_hit)
		begin
			nxt_pwm_lvl = 1'b0;
		end
	end

	// Read mux, registered at setup so prdata comes from a flop.
	always @*
	begin
		nxt_prdata   = 32'h0000_0000;
		nxt_unmapped = 1'b0;
		case (paddr)
			`PES_OFS_RISE_SEL:  nxt_prdata[7:0] = rise_sel_ff;
			`PES_OFS_FALL_SEL:  nxt_prdata[7:0] = fall_sel_ff;
			`PES_OFS_PER_SEL:   nxt_prdata[7:0] = per_sel_ff;
			`PES_OFS_SD_CTRL:   nxt_prdata[7:0] = sd_ctrl_ff;
			`PES_OFS_SD_LEVELS: nxt_prdata[7:0] = sd_lvl_ff;
			`PES_OFS_SD_SRC:    nxt_prdata[7:0] = sd_src_ff;
			`PES_OFS_TB_LOW:    nxt_prdata[7:0] = tb_cnt_ff[7:0];
			`PES_OFS_IRQ_STAT:  nxt_prdata[3:0] = irq_stat_ff;
			`PES_OFS_IRQ_CLR:   nxt_prdata[3:0] = 4'h0;
			`PES_OFS_IRQ_EN:    nxt_prdata[3:0] = irq_en_ff;
			default:            nxt_unmapped    = 1'b1;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1_ff    <= 4'h0;
			sync2_ff    <= 4'h0;
			src_q_ff    <= 4'h0;
			trip_q_ff   <= 1'b0;
			rise_sel_ff <= `PES_RST_BYTE;
			fall_sel_ff <= `PES_RST_BYTE;
			per_sel_ff  <= `PES_RST_BYTE;
			sd_ctrl_ff  <= `PES_RST_BYTE;
			sd_lvl_ff   <= `PES_RST_BYTE;
			sd_src_ff   <= `PES_RST_BYTE;
			tb_cnt_ff   <= `PES_RST_COUNT;
			irq_stat_ff <= 4'h0;
			irq_en_ff   <= 4'h0;
			pwm_lvl_ff  <= 1'b0;
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			pwm_out     <= 6'h00;
			rise_evt    <= 1'b0;
			fall_evt    <= 1'b0;
			period_evt  <= 1'b0;
			shutdown_active <= 1'b0;
			irq         <= 1'b0;
		end
		else if (ce)
		begin
			// Pins and comparators are asynchronous to this clock.
			sync1_ff  <= {cmp3_in, cmp2_in, cmp1_in, trip_pin};
			sync2_ff  <= sync1_ff;
			src_q_ff  <= sync2_ff;
			trip_q_ff <= trip_lvl;
			if (wr_acc)
			begin
				// writes to unimplemented bits are dropped
				case (paddr)
					`PES_OFS_RISE_SEL:  rise_sel_ff <= wbyte & `PES_MASK_SEL;
					`PES_OFS_FALL_SEL:  fall_sel_ff <= wbyte & `PES_MASK_SEL;
					`PES_OFS_PER_SEL:   per_sel_ff  <= wbyte & `PES_MASK_SEL;
					// levels C to F absent on second instance
					`PES_OFS_SD_LEVELS: sd_lvl_ff   <= wbyte & LVL_MASK;
					`PES_OFS_SD_SRC:    sd_src_ff   <= wbyte & `PES_MASK_SD_SRC;
					`PES_OFS_IRQ_EN:    irq_en_ff   <= wbyte[3:0];
					default:            irq_en_ff   <= irq_en_ff;
				endcase
			end
			sd_ctrl_ff  <= nxt_sd_ctrl;
			tb_cnt_ff   <= nxt_tb_cnt;
			irq_stat_ff <= nxt_irq_stat;
			pwm_lvl_ff  <= nxt_pwm_lvl;
			// One wait-free access phase: pready is high in every access cycle.
			pready  <= setup_ph;
			pslverr <= setup_ph & nxt_unmapped;
			if (setup_ph)
			begin
				prdata <= nxt_prdata;
			end
			// forced outputs take their level bits
			if (forced)
			begin
				pwm_out <= sd_lvl_ff[5:0];
			end
			else
			begin
				pwm_out <= {6{pwm_lvl_ff}};
			end
			rise_evt   <= rise_hit;
			fall_evt   <= fall_hit;
			period_evt <= per_hit;
			// status visible while outputs are held
			shutdown_active <= forced;
			irq <= |(nxt_irq_stat & irq_en_ff);
		end
	end

endmodule // pes_event_shutdown

/* File: pkg/pes_defs.vh */
// Functional notes
// - Any enabled rising source (pin, comparators, phase match) fires a rising event.
// - Phase match source fires when time base counter equals phase count.
// - Any enabled falling source (pin, comparators, duty match) fires a falling event.
// - Any enabled period source fires a period event and clears the counter.
// - Each period enable bit gates its own source; cleared bits block it.
// - Shutdown status sets on shutdown, forces output levels; software may set it.
// - Shutdown event forces levels, sets flag; restart automatic or by software clear.
// - Override with shutdown enabled forces levels without the flag; otherwise ignored.
// - Each output A to F drives its level bit while shut down.
// - Second instance has level bits only for outputs A and B.
// - Pin or comparator with its enable bit set causes shutdown.
// - Time base low byte register reads and writes counter bits 7 to 0.
// - Duty match source fires falling event when counter equals duty count.
`ifndef PES_DEFS_VH
`define PES_DEFS_VH
`define PES_OFS_RISE_SEL   8'h00
`define PES_OFS_FALL_SEL   8'h04
`define PES_OFS_PER_SEL    8'h08
`define PES_OFS_SD_CTRL    8'h0c
`define PES_OFS_SD_LEVELS  8'h10
`define PES_OFS_SD_SRC     8'h14
`define PES_OFS_TB_LOW     8'h18
`define PES_OFS_IRQ_STAT   8'h1c
`define PES_OFS_IRQ_CLR    8'h20
`define PES_OFS_IRQ_EN     8'h24
`define PES_MASK_SEL       8'h8f
`define PES_MASK_SD_SRC    8'h8e
`define PES_MASK_SD_CTRL   8'he1
`define PES_MASK_LVL_FULL  8'h3f
`define PES_MASK_LVL_TWO   8'h03
`define PES_MASK_IRQ       8'h0f
`define PES_BIT_TB         0
`define PES_BIT_STATUS     7
`define PES_BIT_SD_EN      6
`define PES_BIT_RESTART    5
`define PES_BIT_OVERRIDE   0
`define PES_IRQ_RISE       0
`define PES_IRQ_FALL       1
`define PES_IRQ_PERIOD     2
`define PES_IRQ_SHUTDOWN   3
`define PES_RST_BYTE       8'h00
`define PES_RST_COUNT      16'h0000
`endif

/* File: dv/pes_cmp_model.sv */
`timescale 1ns/1ps
module pes_cmp_model (
	input wire       clk_sys,
	input wire [3:0] req,
	output reg       trip_pin,
	output reg       cmp1_in,
	output reg       cmp2_in,
	output reg       cmp3_in
);
	// Levels move just after an edge; the block treats them as asynchronous anyway.
	always @(posedge clk_sys)
	begin
		{trip_pin, cmp3_in, cmp2_in, cmp1_in} <= req;
	end
endmodule // pes_cmp_model

/* File: dv/pes_es_asserts.sv */
`timescale 1ns/1ps
module pes_es_asserts (
	input wire        clk_sys,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [5:0]  pwm_out,
	input wire        rise_evt,
	input wire        shutdown_active,
	input wire        irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h24 |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr <= 8'h24
		&& paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access refused");
	a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_forced_hold: assert property (shutdown_active && $past(shutdown_active)
		&& !$past(pready, 2) |-> $stable(pwm_out)) else $error("forced levels moved");
	a_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
		rst |=> !irq && !shutdown_active && pwm_out == 6'h00 && !rise_evt)
		else $error("outputs not quiet after reset");
endmodule // pes_es_asserts
bind pes_event_shutdown pes_es_asserts i_pes_es_asserts (.clk_sys, .rst, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .pwm_out, .rise_evt, .shutdown_active, .irq);

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        clk_sys = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] phase_count = 16'h0010;
	logic [15:0] duty_count = 16'h0018;
	logic [15:0] period_count = 16'h0020;
	logic [3:0]  req = 4'h0;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h24};
	logic [31:0] msk [6] = '{32'h8f, 32'h8f, 32'h8f, 32'h3f, 32'h8e, 32'h0f};
	int          num_errors = 0;
	int          n_compared = 0;
	int          n;
	wire [31:0]  prdata;
	wire [5:0]   pwm_out;
	wire         pready, pslverr, trip_pin, cmp1_in, cmp2_in, cmp3_in;
	wire         rise_evt, fall_evt, period_evt, shutdown_active, irq;
	wire [4:0]   ev = {~shutdown_active, shutdown_active, period_evt, fall_evt, rise_evt};
	always #10 clk_sys = ~clk_sys;
	pes_event_shutdown i_pes_event_shutdown (.clk_sys, .rst, .ce(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trip_pin, .cmp1_in, .cmp2_in,
		.cmp3_in, .phase_count, .duty_count, .period_count, .pwm_out, .rise_evt, .fall_evt,
		.period_evt, .shutdown_active, .irq);
	pes_cmp_model i_pes_cmp_model (.clk_sys, .req, .trip_pin, .cmp1_in, .cmp2_in, .cmp3_in);
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		i = 0;
		// The answer is taken at the rising edge where pready is sampled high.
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
		begin
			num_errors++;
			summarize;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(rd, e);
	endtask
	task trip(input logic [3:0] v);
		@(posedge clk_sys);
		req <= v;
	endtask
	// The count of negedges up to the event, or zero when it never came.
	task wait_ev(input int s, input int lim);
		n = 0;
		for (int k = 1; k <= lim && n == 0; k++)
		begin
			@(negedge clk_sys);
			if (ev[s] === 1'b1)
				n = k;
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		foreach (adr[j])
		begin
			rdc(adr[j], 32'h0);
			apb(1, adr[j], 32'hffffffff);
			rdc(adr[j], msk[j]);
			apb(1, adr[j], 32'h0);
		end
		rdc(8'h28, 32'h0);
		chk(er, 1'b1);
		rdc(8'h20, 32'h0);
		apb(1, 8'h18, 32'h5a);
		rdc(8'h18, 32'h5b);
		$display("registers done");
		apb(1, 8'h18, 32'h0);
		apb(1, 8'h24, 32'hf);
		apb(1, 8'h08, 32'h1);
		apb(1, 8'h00, 32'h1);
		apb(1, 8'h04, 32'h1);
		wait_ev(2, 100);
		wait_ev(0, 100);
		chk(n, 17);
		wait_ev(1, 100);
		chk(n, 8);
		wait_ev(2, 100);
		chk(n, 8);
		rdc(8'h1c, 32'h7);
		chk(irq, 1'b1);
		apb(1, 8'h08, 32'h0);
		wait_ev(2, 80);
		chk(n, 0);
		apb(1, 8'h00, 32'h2);
		apb(1, 8'h04, 32'h0);
		apb(1, 8'h20, 32'hf);
		rdc(8'h1c, 32'h0);
		chk(irq, 1'b0);
		$display("time base done");
		apb(1, 8'h24, 32'he);
		trip(4'h2);
		wait_ev(0, 10);
		chk(n, 0);
		trip(4'h3);
		wait_ev(0, 10);
		chk(n > 0, 1'b1);
		rdc(8'h1c, 32'h1);
		chk(irq, 1'b0);
		apb(1, 8'h24, 32'hf);
		rdc(8'h1c, 32'h1);
		chk(irq, 1'b1);
		trip(4'h0);
		apb(1, 8'h20, 32'hf);
		$display("comparators done");
		apb(1, 8'h10, 32'h2d);
		apb(1, 8'h14, 32'h2);
		apb(1, 8'h0c, 32'h40);
		trip(4'h2);
		wait_ev(3, 10);
		chk(n, 0);
		trip(4'h3);
		wait_ev(3, 10);
		chk(n > 0, 1'b1);
		chk(pwm_out, 6'h2d);
		rdc(8'h0c, 32'hc0);
		chk(irq, 1'b1);
		trip(4'h0);
		repeat (10) @(negedge clk_sys);
		chk(shutdown_active, 1'b1);
		apb(1, 8'h0c, 32'h60);
		repeat (2) @(negedge clk_sys);
		chk(shutdown_active, 1'b0);
		trip(4'h1);
		wait_ev(3, 10);
		chk(n > 0, 1'b1);
		trip(4'h0);
		wait_ev(4, 10);
		chk(n > 0, 1'b1);
		apb(1, 8'h20, 32'hf);
		apb(1, 8'h0c, 32'h41);
		repeat (2) @(negedge clk_sys);
		chk(pwm_out, 6'h2d);
		rdc(8'h1c, 32'h0);
		apb(1, 8'h0c, 32'h01);
		repeat (2) @(negedge clk_sys);
		chk(shutdown_active, 1'b0);
		apb(1, 8'h0c, 32'h80);
		repeat (2) @(negedge clk_sys);
		chk(shutdown_active, 1'b1);
		chk(pwm_out, 6'h2d);
		$display("shutdown done");
		summarize;
	end
endmodule // tb
